// >>> hdl/serial_eeprom_config_loader.v
// serial memory configuration loader with software pin access
`timescale 1ns/1ps
`include "cfg_loader_regs.vh"
`default_nettype none

module serial_eeprom_config_loader #(
  parameter [11:0] SIGNATURE = 12'hA5C, // arbitrary value
  parameter [15:0] DEF_VENDOR = 16'h1234, // arbitrary value
  parameter [15:0] DEF_SUBSYS_VENDOR = 16'h1234 // arbitrary value
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire reload_req_i,
  input wire sw_clk_i,
  input wire sw_cs_i,
  input wire sw_do_i,
  output wire sw_di_o,
  output reg mem_clk_o,
  output reg mem_cs_o,
  output reg mem_do_o,
  input wire mem_di_i,
  output wire load_busy_o,
  output reg prog_valid_o,
  output reg no_mem_o,
  output reg [7:0] lcc_low_o,
  output wire io_pin_wake_enable_o,
  output reg [23:0] multi_io_config_register_o,
  output reg [31:0] bus_timing_first_o,
  output reg [31:0] bus_timing_second_o,
  output reg [15:0] global_irq_summary_mask_o,
  output reg [15:0] vendor_id_o,
  output reg [15:0] subsys_vendor_id_o,
  output reg cfg_wr_o,
  output reg [2:0] cfg_func_o,
  output reg [6:0] cfg_offset_o,
  output reg [7:0] cfg_data_o
);

  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [2:0] S_START = 3'h0;
  localparam [2:0] S_GAP = 3'h1;
  localparam [2:0] S_XFER = 3'h2;
  localparam [2:0] S_PROC = 3'h3;
  localparam [2:0] S_DONE = 3'h4;
  // divider count is a 32-bit constant, trimmed to the 4-bit counter on purpose
  localparam integer HALF_CYC_FULL = `LINK_HALF_CYC;
  localparam [3:0] HALF_CYC = HALF_CYC_FULL[3:0];
  localparam [4:0] LAST_PULSE = `CMD_LEN + `WORD_BITS - 5'h01;

  // ----------------------------------------------------------------
  // next present zone after the given one
  // shared by the header decode and the local and identification zone ends
  // ----------------------------------------------------------------
  function [2:0] next_zone;
    input [2:0] present;
    input [2:0] after;
    begin
      if (after < `ZONE_LOCAL && present[`HDR_LOCAL_BIT]) begin
        next_zone = `ZONE_LOCAL;
      end else if (after < `ZONE_IDENT && present[`HDR_IDENT_BIT]) begin
        next_zone = `ZONE_IDENT;
      end else if (after < `ZONE_BUSHDR && present[`HDR_BUSCFG_BIT]) begin
        next_zone = `ZONE_BUSHDR;
      end else begin
        next_zone = `ZONE_NONE;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] zone_reg;
  reg [2:0] present_reg;
  reg [3:0] div_reg;
  reg [4:0] pulse_reg;
  reg [8:0] cmd_reg;
  reg [15:0] word_reg;
  reg [5:0] addr_reg;
  reg di_meta_reg;
  reg di_sync_reg;
  reg [2:0] zone_next;

  // fields of the word just read, and the divider tick
  wire [6:0] ofs = word_reg[`WORD_OFS_HI:`WORD_OFS_LO];
  wire [7:0] dat = word_reg[`WORD_DATA_HI:`WORD_DATA_LO];
  wire cont = word_reg[`WORD_CONT_BIT];
  wire tick = (div_reg == HALF_CYC - 4'h1);

  // status and software read-back of the data line
  assign load_busy_o = (state_reg != S_DONE);
  assign io_pin_wake_enable_o = lcc_low_o[7];
  assign sw_di_o = di_sync_reg;

  // ----------------------------------------------------------------
  // data-in synchroniser
  // ----------------------------------------------------------------
  // the data pin is asynchronous to the system clock, so two flops
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      di_meta_reg <= 1'b0;
      di_sync_reg <= 1'b0;
    end else begin
      di_meta_reg <= mem_di_i;
      di_sync_reg <= di_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // zone to follow the word just read
  // ----------------------------------------------------------------
  always @* begin
    zone_next = zone_reg;
    case (zone_reg)
      `ZONE_HEADER: begin
        zone_next = next_zone(word_reg[2:0], `ZONE_NONE);
      end
      `ZONE_LOCAL: begin
        if (!cont) begin
          zone_next = next_zone(present_reg, `ZONE_LOCAL);
        end
      end
      `ZONE_IDENT: begin
        if (!cont) begin
          zone_next = next_zone(present_reg, `ZONE_IDENT);
        end
      end
      `ZONE_BUSHDR: begin
        zone_next = cont ? `ZONE_BUSDATA : `ZONE_NONE;
      end
      `ZONE_BUSDATA: begin
        zone_next = cont ? `ZONE_BUSDATA : `ZONE_BUSHDR;
      end
      default: begin
        zone_next = `ZONE_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer, link pins and loaded registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_START;
      zone_reg <= `ZONE_HEADER;
      present_reg <= 3'h0;
      div_reg <= 4'h0;
      pulse_reg <= 5'h00;
      cmd_reg <= 9'h000;
      word_reg <= 16'h0000;
      addr_reg <= 6'h00;
      mem_clk_o <= 1'b0;
      mem_cs_o <= 1'b0;
      mem_do_o <= 1'b0;
      prog_valid_o <= 1'b0;
      no_mem_o <= 1'b0;
      lcc_low_o <= `DEF_LCC0;
      multi_io_config_register_o <= `DEF_MIC;
      bus_timing_first_o <= `DEF_BT1;
      bus_timing_second_o <= `DEF_BT2;
      global_irq_summary_mask_o <= `DEF_GIS_MASK;
      vendor_id_o <= DEF_VENDOR;
      subsys_vendor_id_o <= DEF_SUBSYS_VENDOR;
      cfg_wr_o <= 1'b0;
      cfg_func_o <= 3'h0;
      cfg_offset_o <= 7'h00;
      cfg_data_o <= 8'h00;
    end else begin
      cfg_wr_o <= 1'b0;
      case (state_reg)
        // restore defaults and begin at the header word
        S_START: begin
          lcc_low_o <= `DEF_LCC0;
          multi_io_config_register_o <= `DEF_MIC;
          bus_timing_first_o <= `DEF_BT1;
          bus_timing_second_o <= `DEF_BT2;
          global_irq_summary_mask_o <= `DEF_GIS_MASK;
          vendor_id_o <= DEF_VENDOR;
          subsys_vendor_id_o <= DEF_SUBSYS_VENDOR;
          prog_valid_o <= 1'b0;
          no_mem_o <= 1'b0;
          // stale zone flags must not survive a reload
          present_reg <= 3'h0;
          zone_reg <= `ZONE_HEADER;
          addr_reg <= 6'h00;
          mem_cs_o <= 1'b0;
          mem_clk_o <= 1'b0;
          mem_do_o <= 1'b0;
          div_reg <= 4'h0;
          state_reg <= S_GAP;
        end
        // select low for a half period, then frame a read
        // the pause returns the memory to standby between words
        S_GAP: begin
          div_reg <= tick ? 4'h0 : div_reg + 4'h1;
          if (tick) begin
            cmd_reg <= {`MEM_READ_CMD, addr_reg};
            mem_do_o <= 1'b1;
            mem_cs_o <= 1'b1;
            pulse_reg <= 5'h00;
            state_reg <= S_XFER;
          end
        end
        // one clock pulse per bit; sample at the end of the high phase
        S_XFER: begin
          div_reg <= tick ? 4'h0 : div_reg + 4'h1;
          if (tick && !mem_clk_o) begin
            mem_clk_o <= 1'b1;
          end else if (tick) begin
            mem_clk_o <= 1'b0;
            cmd_reg <= {cmd_reg[7:0], 1'b0};
            mem_do_o <= cmd_reg[7];
            pulse_reg <= pulse_reg + 5'h01;
            // a pulled-up line where the dummy zero belongs means no memory
            if (pulse_reg == `CMD_LEN - 5'h01 && di_sync_reg) begin
              no_mem_o <= 1'b1;
              mem_cs_o <= 1'b0;
              mem_do_o <= 1'b0;
              state_reg <= S_DONE;
            end else if (pulse_reg >= `CMD_LEN) begin
              word_reg <= {word_reg[14:0], di_sync_reg};
              if (pulse_reg == LAST_PULSE) begin
                mem_cs_o <= 1'b0;
                mem_do_o <= 1'b0;
                state_reg <= S_PROC;
              end
            end
          end
        end
        // act on the completed word
        // register writes land one cycle after the last data bit
        S_PROC: begin
          div_reg <= 4'h0;
          case (zone_reg)
            `ZONE_HEADER: begin
              if (word_reg[`HDR_SIG_HI:`HDR_SIG_LO] == SIGNATURE) begin
                prog_valid_o <= 1'b1;
                present_reg <= word_reg[2:0];
              end
            end
            `ZONE_LOCAL: begin
              // byte lanes of the local block
              case (ofs)
                `OFS_LCC0: lcc_low_o <= dat;
                `OFS_MIC0: multi_io_config_register_o[7:0] <= dat;
                `OFS_MIC1: multi_io_config_register_o[15:8] <= dat;
                `OFS_MIC2: multi_io_config_register_o[23:16] <= dat;
                `OFS_BT1_0: bus_timing_first_o[7:0] <= dat;
                `OFS_BT1_1: bus_timing_first_o[15:8] <= dat;
                `OFS_BT1_2: bus_timing_first_o[23:16] <= dat;
                `OFS_BT1_3: bus_timing_first_o[31:24] <= dat;
                `OFS_BT2_0: bus_timing_second_o[7:0] <= dat;
                `OFS_BT2_1: bus_timing_second_o[15:8] <= dat;
                `OFS_BT2_2: bus_timing_second_o[23:20] <= dat[7:4];
                `OFS_BT2_3: bus_timing_second_o[31:24] <= {dat[7:6], 1'b0, dat[4:0]};
                `OFS_GIS2: global_irq_summary_mask_o[7:0] <= dat;
                `OFS_GIS3: global_irq_summary_mask_o[15:8] <= dat;
                default: lcc_low_o <= lcc_low_o; // other offsets ignored
              endcase
            end
            `ZONE_IDENT: begin
              // vendor code bytes; higher selectors ignored
              case (ofs)
                `ID_VEN_LO: vendor_id_o[7:0] <= dat;
                `ID_VEN_HI: vendor_id_o[15:8] <= dat;
                `ID_SVEN_LO: subsys_vendor_id_o[7:0] <= dat;
                `ID_SVEN_HI: subsys_vendor_id_o[15:8] <= dat;
                default: vendor_id_o <= vendor_id_o;
              endcase
            end
            `ZONE_BUSHDR: begin
              cfg_func_o <= word_reg[`FUNC_HI:`FUNC_LO];
            end
            `ZONE_BUSDATA: begin
              cfg_wr_o <= 1'b1;
              cfg_offset_o <= ofs;
              cfg_data_o <= dat;
            end
            default: begin
              cfg_wr_o <= 1'b0;
            end
          endcase
          // advance or finish
          // the address limit keeps a blank memory from reading forever
          if (zone_reg == `ZONE_HEADER && word_reg[`HDR_SIG_HI:`HDR_SIG_LO] != SIGNATURE) begin
            state_reg <= S_DONE;
          end else if (zone_next == `ZONE_NONE || addr_reg == `LAST_ADDR) begin
            state_reg <= S_DONE;
          end else begin
            zone_reg <= zone_next;
            addr_reg <= addr_reg + 6'h01;
            state_reg <= S_GAP;
          end
        end
        // pins follow software; a reload starts over
        S_DONE: begin
          mem_clk_o <= sw_clk_i;
          mem_cs_o <= sw_cs_i;
          mem_do_o <= sw_do_i;
          if (reload_req_i) begin
            state_reg <= S_START;
          end
        end
        default: begin
          state_reg <= S_START;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> hdl/cfg_loader_regs.vh
// constants for the serial memory configuration loader
`ifndef CFG_LOADER_REGS_VH
`define CFG_LOADER_REGS_VH

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
`define SYS_CLK_NS 40
`define LINK_HALF_NS 160
`define LINK_HALF_CYC ((`LINK_HALF_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

// ----------------------------------------------------------------
// memory command framing
// ----------------------------------------------------------------
`define MEM_ADDR_BITS 6
`define MEM_READ_CMD 3'h6
`define CMD_LEN 5'h09
`define WORD_BITS 5'h10
`define LAST_ADDR 6'h3F

// ----------------------------------------------------------------
// header word fields
// ----------------------------------------------------------------
`define HDR_SIG_HI 15
`define HDR_SIG_LO 4
`define HDR_LOCAL_BIT 2
`define HDR_IDENT_BIT 1
`define HDR_BUSCFG_BIT 0

// ----------------------------------------------------------------
// data word fields
// ----------------------------------------------------------------
`define WORD_CONT_BIT 15
`define WORD_OFS_HI 14
`define WORD_OFS_LO 8
`define WORD_DATA_HI 7
`define WORD_DATA_LO 0
`define FUNC_HI 2
`define FUNC_LO 0

// ----------------------------------------------------------------
// zone codes
// ----------------------------------------------------------------
`define ZONE_NONE 3'h0
`define ZONE_LOCAL 3'h1
`define ZONE_IDENT 3'h2
`define ZONE_BUSHDR 3'h3
`define ZONE_BUSDATA 3'h4
`define ZONE_HEADER 3'h5

// ----------------------------------------------------------------
// local byte offsets
// ----------------------------------------------------------------
`define OFS_LCC0 7'h00
`define OFS_MIC0 7'h04
`define OFS_MIC1 7'h05
`define OFS_MIC2 7'h06
`define OFS_BT1_0 7'h08
`define OFS_BT1_1 7'h09
`define OFS_BT1_2 7'h0A
`define OFS_BT1_3 7'h0B
`define OFS_BT2_0 7'h0C
`define OFS_BT2_1 7'h0D
`define OFS_BT2_2 7'h0E
`define OFS_BT2_3 7'h0F
`define OFS_GIS2 7'h1E
`define OFS_GIS3 7'h1F

// ----------------------------------------------------------------
// identification selectors
// ----------------------------------------------------------------
`define ID_VEN_LO 7'h00
`define ID_VEN_HI 7'h01
`define ID_SVEN_LO 7'h02
`define ID_SVEN_HI 7'h03

// ----------------------------------------------------------------
// built-in defaults
// ----------------------------------------------------------------
`define DEF_LCC0 8'h00
`define DEF_MIC 24'h000000
`define DEF_BT1 32'h00000000
`define DEF_BT2 32'h00000000
`define DEF_GIS_MASK 16'h0000

`endif

// >>> bench/loader_monitor.sv
// concurrent checks on the configuration loader ports
`timescale 1ns/1ps
`include "cfg_loader_regs.vh"
`default_nettype none
module loader_monitor #(
  parameter [15:0] DEF_VENDOR = 16'h1234 // arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sw_clk_i,
  input wire logic sw_cs_i,
  input wire logic sw_do_i,
  input wire logic mem_clk_o,
  input wire logic mem_cs_o,
  input wire logic mem_do_o,
  input wire logic load_busy_o,
  input wire logic prog_valid_o,
  input wire logic no_mem_o,
  input wire logic [15:0] vendor_id_o,
  input wire logic [31:0] bus_timing_second_o,
  input wire logic cfg_wr_o
);
  // ----------------------------------------------------------------
  // link framing and load results
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_sw_pins_follow: assert property ($past(rst_n_i) && $past(!load_busy_o) && !load_busy_o |->
    {mem_clk_o, mem_cs_o, mem_do_o} == $past({sw_clk_i, sw_cs_i, sw_do_i})) else $error("pins not following software");
  a_wr_single: assert property (cfg_wr_o |=> !cfg_wr_o) else $error("config write pulse too long");
  a_wr_in_load: assert property (cfg_wr_o |-> $past(load_busy_o) && prog_valid_o && !no_mem_o)
    else $error("config write outside a valid load");
  a_start_bit: assert property (load_busy_o && $rose(mem_cs_o) |-> mem_do_o && !mem_clk_o)
    else $error("frame does not open with start bit");
  a_clk_high_four: assert property (load_busy_o && $rose(mem_clk_o) |-> mem_clk_o[*4] ##1 !mem_clk_o)
    else $error("link clock high phase wrong");
  a_clk_low_four: assert property (load_busy_o && $fell(mem_clk_o) |-> !mem_clk_o[*4])
    else $error("link clock low phase too short");
  a_clk_in_frame: assert property (load_busy_o && mem_clk_o |-> mem_cs_o) else $error("clock outside frame");
  a_gap_low: assert property (load_busy_o && $fell(mem_cs_o) |-> !mem_cs_o[*4]) else $error("gap too short");
  a_valid_in_load: assert property ($rose(prog_valid_o) |-> $past(load_busy_o))
    else $error("valid flag set while idle");
  a_frozen_done: assert property ($past(rst_n_i) && $past(!load_busy_o) && !load_busy_o |->
    $stable(prog_valid_o) && $stable(vendor_id_o) && $stable(bus_timing_second_o) && !cfg_wr_o)
    else $error("registers change after load end");
  a_nomem_defaults: assert property (no_mem_o |-> !prog_valid_o && vendor_id_o == DEF_VENDOR &&
    bus_timing_second_o == `DEF_BT2) else $error("defaults lost without memory");
  a_resv_bit: assert property (bus_timing_second_o[29] == 1'b0) else $error("reserved timing bit set");
  c_cfg_write: cover property (cfg_wr_o);
  c_valid: cover property ($rose(prog_valid_o));
  c_no_mem: cover property ($rose(no_mem_o));
endmodule
bind serial_eeprom_config_loader loader_monitor #(.DEF_VENDOR(DEF_VENDOR)) mon_u (.clk_sys_i, .rst_n_i, .sw_clk_i,
  .sw_cs_i, .sw_do_i, .mem_clk_o, .mem_cs_o, .mem_do_o, .load_busy_o, .prog_valid_o, .no_mem_o, .vendor_id_o,
  .bus_timing_second_o, .cfg_wr_o);
`default_nettype wire

// >>> bench/serial_memory_model.sv
// behavioural serial memory of 16-bit words for the loader bench
`timescale 1ns/1ps
`default_nettype none
module serial_memory_model (
  input wire logic mem_clk_i,
  input wire logic mem_cs_i,
  input wire logic mem_do_i,
  input wire logic fitted_i,
  output wire logic mem_di_o
);
  logic [15:0] mem [0:63];
  logic [7:0] cmd_reg = 8'h00;
  logic [5:0] addr_reg = 6'h00;
  logic dq_reg = 1'b1;
  int k = 0;
  // released line or empty socket reads as the pull-up level
  assign mem_di_o = (fitted_i && mem_cs_i) ? dq_reg : 1'b1;
  // take start, opcode and address, then answer dummy zero and the word
  always @(posedge mem_clk_i or negedge mem_cs_i) begin
    if (!mem_cs_i) begin
      k <= 0;
      dq_reg <= 1'b1;
    end else begin
      k <= k + 1;
      if (k < 8) cmd_reg <= {cmd_reg[6:0], mem_do_i};
      if (k == 8 && cmd_reg[7:5] == 3'h6) begin
        addr_reg <= {cmd_reg[4:0], mem_do_i};
        dq_reg <= 1'b0;
      end
      if (k >= 9 && k <= 24) dq_reg <= mem[addr_reg][24 - k];
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the serial memory configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [11:0] SIG = 12'hA5C; // arbitrary value
  localparam logic [15:0] DEFV = 16'h1234; // arbitrary value
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reload_req_i = 1'b0;
  logic sw_clk_i = 1'b0;
  logic sw_cs_i = 1'b0;
  logic sw_do_i = 1'b0;
  logic fitted = 1'b0;
  wire sw_di_o, mem_clk_o, mem_cs_o, mem_do_o, mem_di_i, load_busy_o, prog_valid_o, no_mem_o, wake_o, cfg_wr_o;
  wire [7:0] lcc_low_o, cfg_data_o;
  wire [23:0] mic_o;
  wire [31:0] bt1_o, bt2_o;
  wire [15:0] gis_o, ven_o, sven_o;
  wire [2:0] cfg_func_o;
  wire [6:0] cfg_offset_o;
  int miscompares = 0;
  int n_compared = 0;
  int n_wr = 0;
  logic [17:0] last_wr = 18'h00000;
  // ----------------------------------------------------------------
  // clock, design, memory and write recorder
  // ----------------------------------------------------------------
  always #20 clk_sys_i = ~clk_sys_i;
  serial_eeprom_config_loader #(.SIGNATURE(SIG), .DEF_VENDOR(DEFV), .DEF_SUBSYS_VENDOR(DEFV)) dut_u (
    .clk_sys_i, .rst_n_i, .reload_req_i, .sw_clk_i, .sw_cs_i, .sw_do_i, .sw_di_o, .mem_clk_o, .mem_cs_o,
    .mem_do_o, .mem_di_i, .load_busy_o, .prog_valid_o, .no_mem_o, .lcc_low_o, .io_pin_wake_enable_o(wake_o),
    .multi_io_config_register_o(mic_o), .bus_timing_first_o(bt1_o), .bus_timing_second_o(bt2_o),
    .global_irq_summary_mask_o(gis_o), .vendor_id_o(ven_o), .subsys_vendor_id_o(sven_o), .cfg_wr_o,
    .cfg_func_o, .cfg_offset_o, .cfg_data_o);
  serial_memory_model mem_u (.mem_clk_i(mem_clk_o), .mem_cs_i(mem_cs_o), .mem_do_i(mem_do_o), .fitted_i(fitted),
    .mem_di_o(mem_di_i));
  // count bus config writes per load and keep the latest
  always @(posedge clk_sys_i) begin
    if (reload_req_i === 1'b1) n_wr <= 0;
    else if (cfg_wr_o === 1'b1) n_wr <= n_wr + 1;
    if (cfg_wr_o === 1'b1) last_wr <= {cfg_func_o, cfg_offset_o, cfg_data_o};
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    repeat (2) @(negedge clk_sys_i);
    while (load_busy_o !== 1'b0 && i < 20000) begin
      @(negedge clk_sys_i);
      i++;
    end
    if (i >= 20000) miscompares++;
  endtask
  task automatic prog_reload(input logic [15:0] ws[$]);
    foreach (ws[i]) mem_u.mem[i] = ws[i];
    reload_req_i = 1'b1;
    @(negedge clk_sys_i);
    reload_req_i = 1'b0;
    wait_done();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic no_memory;
    cmp(no_mem_o, 1'b1);
    cmp(prog_valid_o, 1'b0);
    cmp({ven_o, sven_o}, {DEFV, DEFV});
    cmp(bt2_o | bt1_o | mic_o | gis_o | lcc_low_o, 32'h0);
    cmp(n_wr, 32'h0);
  endtask
  task automatic full_load;
    fitted = 1'b1;
    prog_reload('{{SIG, 4'h7}, 16'h8085, 16'h8411, 16'h8822, 16'h8B33, 16'h8D44, 16'h8FFF, 16'h9E5A, 16'h1FC3,
      16'h80EF, 16'h81BE, 16'h03CA, 16'h8001, 16'h3D07, 16'h0000});
    cmp({prog_valid_o, no_mem_o}, 2'h2);
    cmp({lcc_low_o, wake_o}, 9'h10B);
    cmp(mic_o, 24'h000011);
    cmp(bt1_o, 32'h33000022);
    cmp(bt2_o, 32'hDF004400);
    cmp(gis_o, 16'hC35A);
    cmp({ven_o, sven_o}, 32'hBEEFCA34);
    cmp(n_wr, 32'h1);
    cmp(last_wr, {3'h1, 7'h3D, 8'h07});
  endtask
  task automatic skip_zone;
    prog_reload('{{SIG, 4'h5}, 16'h0422, 16'h8000, 16'h0255, 16'h0000});
    cmp(mic_o, 24'h000022);
    cmp({ven_o, bt1_o[15:0]}, {DEFV, 16'h0000});
    cmp(n_wr, 32'h1);
    cmp(last_wr, {3'h0, 7'h02, 8'h55});
  endtask
  task automatic bad_header;
    prog_reload('{{~SIG, 4'h7}, 16'h0422, 16'h01AA, 16'h8000, 16'h0255, 16'h0000});
    cmp({prog_valid_o, no_mem_o}, 2'h0);
    cmp({mic_o, ven_o}, {24'h0, DEFV});
    cmp(n_wr, 32'h0);
  endtask
  task automatic sw_pins;
    sw_clk_i = 1'b1;
    sw_cs_i = 1'b1;
    sw_do_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    cmp({mem_clk_o, mem_cs_o, mem_do_o, sw_di_o}, 4'hF);
    sw_clk_i = 1'b0;
    sw_cs_i = 1'b0;
    sw_do_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    cmp({mem_clk_o, mem_cs_o, mem_do_o, sw_di_o}, 4'h1);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    wait_done();
    no_memory();
    full_load();
    skip_zone();
    bad_header();
    sw_pins();
    give_verdict();
  end
  // watchdog well beyond four short loads
  initial begin
    #3000000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
